//--- pwm_enc_pkg.sv
// Constants, types and register map of the PWM temperature encoder.
// Contract
// - Pin drives PWM only when configuration enables it; otherwise relay output or serial interface owns it.
// - Two formats: single carries one temperature, extended carries two slots.
// - Frame period comes from a programmable divider of the clock.
// - Config bits 5:4 choose slot contents: 00 amb/obj1, 01 amb/obj2, 11 obj1/obj2.
// - Ambient slots scale with ambient range bytes, object slots with object words.
// - Field value 10 puts object two in first slot, second slot undefined.
// - Single format uses only first slot content and its scaling.
// - Single frame: high eighth, data half, error quarter, low eighth.
// - Data band holds a 10-bit code in 1024 steps.
// - Fatal memory error in single format holds output high, duty 0.875.
// - Extended frame is twice as long, bands in sixteenths.
// - First extended slot: high sixteenth, variable four sixteenths, then low.
// - Second slot: high nine sixteenths, variable four, two band, one low.
// - Fatal error in extended format gives 43.75% and 93.75% duty.
// - Nonzero repeat field N in bits 8:4 emits each frame 2N+1 times.
// - Pin is shared with thermal relay output; one function drives it.
// - Fatal error signalling is optional and enabled per variant.
// - Each temperature is rescaled to 10 bits between programmed minimum and maximum.
// - Clock held low over 1.44 ms switches to serial until wake or reset.
// ****************************************************************
// Package
// ****************************************************************
package pwm_enc_pkg;

  localparam int TEMP_W = 16;
  localparam int CODE_W = 10;
  localparam int POS_W = 12;
  localparam int CFG_W = 6;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_REPEAT = 8'h04;
  localparam logic [7:0] ADDR_DIVIDER = 8'h08;
  localparam logic [7:0] ADDR_AMB_RANGE = 8'h0C;
  localparam logic [7:0] ADDR_OBJ_LOW = 8'h10;
  localparam logic [7:0] ADDR_OBJ_HIGH = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Configuration fields.
  localparam int CFG_PWM_EN = 0;
  localparam int CFG_EXTENDED = 1;
  localparam int CFG_RELAY = 2;
  localparam int CFG_FATAL_SIG = 3;
  localparam int CFG_SEL_LO = 4;
  localparam int CFG_SEL_HI = 5;
  localparam int REP_LO = 4;
  localparam int REP_HI = 8;
  localparam int AMB_BYTE_W = 8;
  localparam int AMB_STEP_SHIFT = 5;

  // Reset values.
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  localparam logic [15:0] DIVIDER_RST = 16'h0010;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Ambient scale base, the lowest ambient code.
  localparam logic [15:0] AMB_BASE = 16'h2DE4;

  // Band edges in divider ticks; one sixteenth of the extended frame is 256 ticks.
  localparam logic [POS_W-1:0] BAND_START_END = 12'h100;
  localparam logic [POS_W-1:0] BAND_VAR_END = 12'h500;
  localparam logic [POS_W-1:0] BAND_ERR_END = 12'h700;
  localparam logic [POS_W-1:0] SINGLE_LAST = 12'h7FF;
  localparam logic [POS_W-1:0] EXT_HALF = 12'h800;
  localparam logic [POS_W-1:0] S2_VAR_START = 12'h900;
  localparam logic [POS_W-1:0] S2_VAR_END = 12'hD00;
  localparam logic [POS_W-1:0] S2_ERR_END = 12'hF00;
  localparam logic [POS_W-1:0] EXT_LAST = 12'hFFF;

  // Switch-to-serial request time.
  localparam int CLK_PERIOD_NS = 8;
  localparam int REQ_TIME_NS = 1440000;
  localparam int REQ_CYCLES_DFLT = (REQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Slot content selections.
  localparam logic [1:0] SEL_AMB_OBJ1 = 2'h0;
  localparam logic [1:0] SEL_AMB_OBJ2 = 2'h1;
  localparam logic [1:0] SEL_OBJ2_ONLY = 2'h2;
  localparam logic [1:0] SEL_OBJ1_OBJ2 = 2'h3;

  typedef enum logic [1:0] {SRC_AMB, SRC_OBJ1, SRC_OBJ2} src_e;
  typedef enum logic [1:0] {PIN_SERIAL, PIN_PWM, PIN_RELAY} pin_mode_e;

endpackage

//--- pwm_rescale.sv
// Rescaler from a temperature word to a saturated PWM data code.
`timescale 1ns/1ps
module pwm_rescale #(
  parameter int W = 16,
  parameter int CW = 10
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Request.
  input wire logic i_start,
  input wire logic [W-1:0] i_value,
  input wire logic [W-1:0] i_low,
  input wire logic [W-1:0] i_high,
  // Result.
  output logic [CW-1:0] o_code,
  output logic o_busy
);

  localparam int NW = W + CW;
  localparam int IW = $clog2(CW);

  logic [NW-1:0] rem_reg;
  logic [NW-1:0] den_reg;
  logic [IW-1:0] idx_reg;
  logic [W-1:0] diff;
  logic [W-1:0] span;
  logic [NW-1:0] num;

  assign diff = i_value - i_low;
  assign span = i_high - i_low;
  assign num = NW'(diff) * NW'({CW{1'b1}});

  // ****************************************************************
  // Long division, one quotient bit per cycle
  // ****************************************************************
  // A serial divider costs ten cycles but saves a wide combinational divide.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_reg <= '0;
      den_reg <= '0;
      idx_reg <= '0;
      o_code <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      if (i_value <= i_low) begin
        o_code <= '0;
        o_busy <= 1'b0;
      end else if (i_value >= i_high) begin
        o_code <= '1;
        o_busy <= 1'b0;
      end else begin
        rem_reg <= num;
        den_reg <= NW'(span) << (CW - 1);
        idx_reg <= IW'(CW - 1);
        o_code <= '0;
        o_busy <= 1'b1;
      end
    end else if (o_busy) begin
      if (rem_reg >= den_reg) begin
        rem_reg <= rem_reg - den_reg;
        o_code[idx_reg] <= 1'b1;
      end
      den_reg <= den_reg >> 1;
      if (idx_reg == '0) begin
        o_busy <= 1'b0;
      end else begin
        idx_reg <= idx_reg - 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Ten busy cycles, written as two runs of five to keep the unrolled form short.
  sequence s_div_run;
    o_busy [*5] ##1 o_busy [*5] ##1 !o_busy;
  endsequence

  a_div_done: assert property ((i_start && i_value > i_low && i_value < i_high) |=> s_div_run)
    else $error("rescale division did not finish in ten cycles");
  a_sat_low: assert property ((i_start && i_value <= i_low) |=> (o_code == '0 && !o_busy))
    else $error("value below minimum did not give zero code");
  a_sat_high: assert property ((i_start && i_value > i_low && i_value >= i_high) |=> o_code == '1)
    else $error("value above maximum did not give full code");
  a_code_hold: assert property ((!i_start && !o_busy) |=> $stable(o_code))
    else $error("code changed without a new start");

endmodule

//--- pwm_temp_encoder.sv
// Top of the PWM temperature encoder: register port, framing and pin control.
`timescale 1ns/1ps
module pwm_temp_encoder
  import pwm_enc_pkg::*;
#(
  parameter int REQ_CYCLES = REQ_CYCLES_DFLT,
  parameter logic [15:0] DIVIDER_RESET = DIVIDER_RST
) (
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Register port.
  input wire logic [7:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  // Measured values.
  input wire logic [TEMP_W-1:0] I_AMB_TEMP,
  input wire logic [TEMP_W-1:0] I_OBJ_TEMP_ONE,
  input wire logic [TEMP_W-1:0] I_OBJ_TEMP_TWO,
  input wire logic I_MEM_FATAL_ERROR,
  // Pin side.
  input wire logic I_SCL,
  input wire logic I_WAKE,
  input wire logic I_RELAY_LEVEL,
  output logic O_PIN_OUT,
  output logic O_PIN_OE_N,
  output logic [1:0] O_PIN_MODE,
  output logic O_FRAME_START
);

  localparam int RW = $clog2(REQ_CYCLES + 1);
  localparam logic [RW-1:0] REQ_CNT = RW'(REQ_CYCLES);

  logic [CFG_W-1:0] cfg_reg;
  logic [4:0] rep_n_reg;
  logic [15:0] divider_reg;
  logic [15:0] amb_range_reg;
  logic [15:0] obj_low_reg;
  logic [15:0] obj_high_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic serial_reg;
  logic [RW-1:0] scl_cnt_reg;
  logic req_hit;
  pin_mode_e drive_sel;
  pin_mode_e mode_reg;
  logic out_reg;
  logic oe_n_reg;
  logic frame_start_reg;
  logic [15:0] div_cnt_reg;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] frame_last;
  logic was_run_reg;
  logic slot_reg;
  logic [5:0] rep_cnt_reg;
  logic ext_run_reg;
  logic fatal_reg;
  logic run;
  logic tick;
  logic frame_start;
  logic group_end;
  logic latch;
  logic level;
  logic [15:0] amb_low;
  logic [15:0] amb_high;
  logic [CODE_W-1:0] code_w [2];

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic src_e slot_src(input logic [1:0] sel, input logic second);
    unique case (sel)
      SEL_AMB_OBJ1: return second ? SRC_OBJ1 : SRC_AMB;
      SEL_AMB_OBJ2: return second ? SRC_OBJ2 : SRC_AMB;
      SEL_OBJ1_OBJ2: return second ? SRC_OBJ2 : SRC_OBJ1;
      SEL_OBJ2_ONLY: return SRC_OBJ2;
    endcase
  endfunction

  function automatic logic band_level(
    input logic [POS_W-1:0] pos,
    input logic ext,
    input logic slot,
    input logic fatal,
    input logic [CODE_W-1:0] q1,
    input logic [CODE_W-1:0] q2
  );
    logic [POS_W-1:0] off;
    off = '0;
    if (ext && slot) begin
      off = pos - S2_VAR_START;
      if (pos < S2_VAR_START) begin
        return 1'b1;
      end else if (pos < S2_VAR_END) begin
        return (off < POS_W'(q2)) || fatal;
      end else if (pos < S2_ERR_END) begin
        return fatal;
      end
      return 1'b0;
    end
    off = pos - BAND_START_END;
    if (pos < BAND_START_END) begin
      return 1'b1;
    end else if (pos < BAND_VAR_END) begin
      return (off < POS_W'(q1)) || fatal;
    end else if (pos < BAND_ERR_END) begin
      return fatal;
    end
    return 1'b0;
  endfunction

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_reg <= CFG_RST;
      rep_n_reg <= '0;
      divider_reg <= DIVIDER_RESET;
      amb_range_reg <= WORD_RST;
      obj_low_reg <= WORD_RST;
      obj_high_reg <= WORD_RST;
    end else if (I_WR) begin
      case (I_ADDR)
        ADDR_CONFIG: cfg_reg <= I_WDATA[CFG_W-1:0];
        ADDR_REPEAT: rep_n_reg <= I_WDATA[REP_HI:REP_LO];
        ADDR_DIVIDER: divider_reg <= I_WDATA;
        ADDR_AMB_RANGE: amb_range_reg <= I_WDATA;
        ADDR_OBJ_LOW: obj_low_reg <= I_WDATA;
        ADDR_OBJ_HIGH: obj_high_reg <= I_WDATA;
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = '0;
    case (I_ADDR)
      ADDR_CONFIG: rdata_next = 16'(cfg_reg);
      ADDR_REPEAT: rdata_next = 16'({rep_n_reg, {REP_LO{1'b0}}});
      ADDR_DIVIDER: rdata_next = divider_reg;
      ADDR_AMB_RANGE: rdata_next = amb_range_reg;
      ADDR_OBJ_LOW: rdata_next = obj_low_reg;
      ADDR_OBJ_HIGH: rdata_next = obj_high_reg;
      ADDR_STATUS: rdata_next = 16'({fatal_reg, rep_cnt_reg, slot_reg, serial_reg, 2'(mode_reg)});
      default: rdata_next = '0;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= I_RD ? rdata_next : 16'h0000;
    end
  end

  // ****************************************************************
  // Pin ownership and switch-to-serial request
  // ****************************************************************
  always_comb begin
    if (serial_reg || !(cfg_reg[CFG_PWM_EN] || cfg_reg[CFG_RELAY])) begin
      drive_sel = PIN_SERIAL;
    end else if (cfg_reg[CFG_RELAY]) begin
      drive_sel = PIN_RELAY;
    end else begin
      drive_sel = PIN_PWM;
    end
  end

  // The count must pass the request time, so the set comes one cycle after it.
  assign req_hit = (drive_sel != PIN_SERIAL) && !I_SCL && (scl_cnt_reg == REQ_CNT);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      scl_cnt_reg <= '0;
    end else if (drive_sel == PIN_SERIAL || I_SCL) begin
      scl_cnt_reg <= '0;
    end else if (scl_cnt_reg != REQ_CNT) begin
      scl_cnt_reg <= scl_cnt_reg + 1'b1;
    end
  end

  // A request that lands with a wake keeps the pin serial.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      serial_reg <= 1'b0;
    end else if (req_hit) begin
      serial_reg <= 1'b1;
    end else if (I_WAKE) begin
      serial_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Frame timing
  // ****************************************************************
  assign run = (drive_sel == PIN_PWM);
  assign tick = run && (({1'b0, div_cnt_reg} + 17'h00001) >= {1'b0, divider_reg});
  assign frame_last = ext_run_reg ? EXT_LAST : SINGLE_LAST;
  assign frame_start = run && (!was_run_reg || (tick && pos_reg == frame_last));
  assign group_end = (rep_cnt_reg == {rep_n_reg, 1'b0});
  assign latch = frame_start && (!was_run_reg || (group_end && !(ext_run_reg && !slot_reg)));

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_cnt_reg <= '0;
    end else if (!run || tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pos_reg <= '0;
    end else if (!run) begin
      pos_reg <= '0;
    end else if (tick) begin
      pos_reg <= (pos_reg == frame_last) ? '0 : pos_reg + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      was_run_reg <= 1'b0;
    end else begin
      was_run_reg <= run;
    end
  end

  // Each slot frame repeats 2N+1 times before the next slot or new data.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rep_cnt_reg <= '0;
      slot_reg <= 1'b0;
    end else if (frame_start) begin
      if (latch || group_end) begin
        rep_cnt_reg <= '0;
      end else begin
        rep_cnt_reg <= rep_cnt_reg + 1'b1;
      end
      if (latch) begin
        slot_reg <= 1'b0;
      end else if (group_end) begin
        slot_reg <= ~slot_reg;
      end
    end
  end

  // Format and error state change only at a latch, so no frame mixes data.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_run_reg <= 1'b0;
      fatal_reg <= 1'b0;
    end else if (latch) begin
      ext_run_reg <= cfg_reg[CFG_EXTENDED];
      fatal_reg <= I_MEM_FATAL_ERROR && cfg_reg[CFG_FATAL_SIG];
    end
  end

  // ****************************************************************
  // Slot content and rescaling
  // ****************************************************************
  assign amb_low = AMB_BASE + 16'({amb_range_reg[AMB_BYTE_W-1:0], {AMB_STEP_SHIFT{1'b0}}});
  assign amb_high = AMB_BASE + 16'({amb_range_reg[2*AMB_BYTE_W-1:AMB_BYTE_W],
                                     {AMB_STEP_SHIFT{1'b0}}});

  for (genvar k = 0; k < 2; k++) begin : g_slot
    src_e src;
    logic [TEMP_W-1:0] raw;
    logic [TEMP_W-1:0] low;
    logic [TEMP_W-1:0] high;

    always_comb begin
      src = slot_src(cfg_reg[CFG_SEL_HI:CFG_SEL_LO], 1'(k));
      unique case (src)
        SRC_AMB: begin
          raw = I_AMB_TEMP;
          low = amb_low;
          high = amb_high;
        end
        SRC_OBJ1: begin
          raw = I_OBJ_TEMP_ONE;
          low = obj_low_reg;
          high = obj_high_reg;
        end
        default: begin
          raw = I_OBJ_TEMP_TWO;
          low = obj_low_reg;
          high = obj_high_reg;
        end
      endcase
    end

    pwm_rescale #(
      .W(TEMP_W),
      .CW(CODE_W)
    ) u_scale (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_start(latch),
      .i_value(raw),
      .i_low(low),
      .i_high(high),
      .o_code(code_w[k]),
      .o_busy()
    );
  end

  // Single format never reaches the second slot, so its settings are unused.
  assign level = band_level(pos_reg, ext_run_reg, slot_reg, fatal_reg,
                            code_w[0], code_w[1]);

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode_reg <= PIN_SERIAL;
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      frame_start_reg <= 1'b0;
    end else begin
      mode_reg <= drive_sel;
      oe_n_reg <= (drive_sel == PIN_SERIAL);
      frame_start_reg <= frame_start;
      unique case (drive_sel)
        PIN_PWM: out_reg <= level;
        PIN_RELAY: out_reg <= I_RELAY_LEVEL;
        default: out_reg <= 1'b0;
      endcase
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_PIN_OUT = out_reg;
  assign O_PIN_OE_N = oe_n_reg;
  assign O_PIN_MODE = 2'(mode_reg);
  assign O_FRAME_START = frame_start_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_pwm_at(logic [POS_W-1:0] lo, logic [POS_W-1:0] hi);
    run && pos_reg >= lo && pos_reg < hi;
  endsequence

  a_serial_release: assert property ((drive_sel == PIN_SERIAL) |=> (O_PIN_OE_N && !O_PIN_OUT))
    else $error("pin not released in serial mode");
  a_pwm_drive: assert property ((run && !cfg_reg[CFG_RELAY]) |=> !O_PIN_OE_N)
    else $error("pin not driven in PWM mode");
  a_start_band: assert property (s_pwm_at(12'h000, BAND_START_END) |=> O_PIN_OUT)
    else $error("start band not high");
  a_single_tail: assert property ((s_pwm_at(BAND_ERR_END, EXT_HALF) and !ext_run_reg) |=> !O_PIN_OUT)
    else $error("single frame tail not low");
  a_fatal_single: assert property ((s_pwm_at(12'h000, BAND_ERR_END) and fatal_reg && !slot_reg) |=> O_PIN_OUT)
    else $error("fatal error not held high");
  a_s1_low_half: assert property ((s_pwm_at(BAND_ERR_END, EXT_LAST) and ext_run_reg && !slot_reg) |=> !O_PIN_OUT)
    else $error("first slot not low after its error band");
  a_s2_head: assert property ((s_pwm_at(12'h000, S2_VAR_START) and ext_run_reg && slot_reg) |=> O_PIN_OUT)
    else $error("second slot head not high");
  a_s2_tail: assert property ((run && ext_run_reg && slot_reg && pos_reg >= S2_ERR_END) |=> !O_PIN_OUT)
    else $error("second slot end not low");
  a_fatal_s2: assert property ((s_pwm_at(12'h000, S2_ERR_END) and ext_run_reg && slot_reg && fatal_reg) |=> O_PIN_OUT)
    else $error("second slot fatal band not high");
  a_group_latch: assert property ((latch && was_run_reg) |-> rep_cnt_reg == {rep_n_reg, 1'b0})
    else $error("data latched before repetitions finished");
  a_request: assert property (req_hit |=> (serial_reg && O_PIN_OE_N == 1'b0) ##1 O_PIN_OE_N)
    else $error("long clock low did not switch to serial");
  a_frame_wrap: assert property ((tick && pos_reg == frame_last) |=> (pos_reg == '0 && frame_start_reg))
    else $error("frame did not restart at its last tick");

endmodule

//--- pwm_capture_host.sv
// Host model that captures high time and period of each PWM frame on the pin.
`timescale 1ns/1ps
module pwm_capture_host (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Shared pin.
  input wire logic i_pin,
  input wire logic i_pin_oe_n,
  // Serial clock line.
  input wire logic i_hold_scl_low,
  output logic o_scl,
  // Capture result.
  output logic o_done,
  output logic [15:0] o_high,
  output logic [15:0] o_period
);
  logic prev_reg;
  logic seen_reg;
  logic [15:0] high_reg;
  logic [15:0] period_reg;
  logic lvl;
  // Only a driven level counts, so a released pin never looks like a frame.
  assign lvl = ~i_pin_oe_n & i_pin;
  // The host keeps the clock high except while told to hold it low for a switch request.
  assign o_scl = ~i_hold_scl_low;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      high_reg <= 16'h0000;
      period_reg <= 16'h0000;
      o_done <= 1'b0;
      o_high <= 16'h0000;
      o_period <= 16'h0000;
    end else begin
      prev_reg <= lvl;
      o_done <= 1'b0;
      if (lvl && !prev_reg) begin
        // A rising edge closes one frame; the first edge has nothing to close.
        o_done <= seen_reg;
        o_high <= high_reg;
        o_period <= period_reg;
        seen_reg <= 1'b1;
        high_reg <= 16'h0001;
        period_reg <= 16'h0001;
      end else begin
        high_reg <= high_reg + 16'(lvl);
        period_reg <= period_reg + 16'h0001;
      end
    end
  end
endmodule

//--- thermometer_pwm_output_encoder_test.sv
// Self-checking testbench of the PWM temperature encoder.
`timescale 1ns/1ps
module thermometer_pwm_output_encoder_test
  import pwm_enc_pkg::*;
;
  localparam int REQ = 20;
  localparam logic [15:0] OLO = 16'h6AB3;
  localparam logic [15:0] OHI = 16'h7E3B;
  localparam logic [15:0] ALO = AMB_BASE + 16'(16'h003C << AMB_STEP_SHIFT);
  localparam logic [15:0] AHI = AMB_BASE + 16'(16'h0099 << AMB_STEP_SHIFT);
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] amb = 16'h0000;
  logic [15:0] o1 = 16'h0000;
  logic [15:0] o2 = 16'h0000;
  logic fatal = 1'b0;
  logic hold = 1'b0;
  logic wake = 1'b0;
  logic relay = 1'b0;
  logic scl, pin_out, pin_oe_n, m_done, frame_st;
  logic [1:0] fs_q = 2'b00;
  logic [1:0] pin_mode;
  logic [15:0] rdata, m_high, m_period;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int checked = 0;
  always #4 clk = ~clk;
  pwm_temp_encoder #(.REQ_CYCLES(REQ), .DIVIDER_RESET(16'h0001)) u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
    .I_RD(rd_s), .O_RDATA(rdata), .I_AMB_TEMP(amb), .I_OBJ_TEMP_ONE(o1),
    .I_OBJ_TEMP_TWO(o2), .I_MEM_FATAL_ERROR(fatal), .I_SCL(scl), .I_WAKE(wake),
    .I_RELAY_LEVEL(relay), .O_PIN_OUT(pin_out), .O_PIN_OE_N(pin_oe_n),
    .O_PIN_MODE(pin_mode), .O_FRAME_START(frame_st)
  );
  pwm_capture_host u_host (
    .i_clk(clk), .i_rst_n(rst_n), .i_pin(pin_out), .i_pin_oe_n(pin_oe_n),
    .i_hold_scl_low(hold), .o_scl(scl), .o_done(m_done), .o_high(m_high),
    .o_period(m_period)
  );
  function automatic logic [15:0] code(input logic [15:0] t, input logic [15:0] lo,
      input logic [15:0] hi);
    if (t <= lo) return 16'h0000;
    if (t >= hi) return 16'h03FF;
    return 16'((32'(t - lo) * 32'h0000_03FF) / 32'(hi - lo));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] want);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check({16'h0000, rdata}, {16'h0000, want});
  endtask
  // Each scenario starts from reset so the first frame begins a repeat group.
  task automatic go(input logic [15:0] cfg, input logic [15:0] rep);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(ADDR_AMB_RANGE, 16'h993C);
    wr(ADDR_OBJ_LOW, OLO);
    wr(ADDR_OBJ_HIGH, OHI);
    wr(ADDR_REPEAT, rep);
    wr(ADDR_CONFIG, cfg);
  endtask
  task automatic want(input logic [15:0] high, input logic [15:0] period);
    exp_q.push_back({high, period});
  endtask
  task automatic drain();
    for (int i = 0; i < 20000 && exp_q.size() > 0; i++) @(posedge clk);
    check(32'(exp_q.size()), 32'h0000_0000);
    exp_q.delete();
  endtask
  // The frame start pulse leads the reported rising edge by two samples and lasts one.
  always @(posedge clk) begin
    fs_q <= {fs_q[0], frame_st};
    if (m_done === 1'b1 && exp_q.size() > 0) begin
      check({m_high, m_period}, exp_q.pop_front());
      check(32'(fs_q), 32'h0000_0002);
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [15:0] c1;
    logic [15:0] c2;
    void'($urandom(99));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(32'({pin_oe_n, pin_mode}), 32'h0000_0004);
    rd_chk(ADDR_DIVIDER, 16'h0001);
    rd_chk(8'h1C, 16'h0000);
    amb <= ALO + 16'($urandom_range(0, 2900));
    fatal <= 1'b1;
    go(16'h0001, 16'h0000);
    repeat (2) want(16'h0100 + code(amb, ALO, AHI), 16'h0800);
    drain();
    go(16'h0009, 16'h0000);
    repeat (2) want(16'h0700, 16'h0800);
    drain();
    fatal <= 1'b0;
    o1 <= OLO - 16'h0005;
    go(16'h0031, 16'h0000);
    repeat (20) @(posedge clk);
    o1 <= OHI + 16'h0040;
    want(16'h0100, 16'h0800);
    want(16'h04FF, 16'h0800);
    drain();
    o1 <= OLO + 16'($urandom_range(0, 3000));
    go(16'h0031, 16'h0010);
    c1 = code(o1, OLO, OHI);
    repeat (20) @(posedge clk);
    o1 <= o1 + 16'h05DC;
    @(posedge clk);
    c2 = code(o1, OLO, OHI);
    repeat (3) want(16'h0100 + c1, 16'h0800);
    want(16'h0100 + c2, 16'h0800);
    drain();
    for (int s = 0; s < 4; s++) begin
      amb <= ALO + 16'($urandom_range(0, 2900));
      o1 <= OLO + 16'($urandom_range(0, 5000));
      o2 <= OLO + 16'($urandom_range(0, 5000));
      fatal <= (s == 2);
      go(16'(s << 4) | (s == 2 ? 16'h000B : 16'h0003), 16'h0000);
      c1 = (s < 2) ? code(amb, ALO, AHI) : code(s == 3 ? o1 : o2, OLO, OHI);
      c2 = code(s == 0 ? o1 : o2, OLO, OHI);
      want(s == 2 ? 16'h0700 : 16'h0100 + c1, 16'h1000);
      want(s == 2 ? 16'h0F00 : 16'h0900 + c2, 16'h1000);
      drain();
    end
    go(16'h0001, 16'h0000);
    hold <= 1'b1;
    repeat (REQ - 5) @(posedge clk);
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(32'({pin_oe_n, pin_mode}), 32'h0000_0001);
    hold <= 1'b1;
    repeat (REQ + 4) @(posedge clk);
    hold <= 1'b0;
    wr(ADDR_CONFIG, 16'h0005);
    repeat (3) @(posedge clk);
    #1;
    check(32'({pin_oe_n, pin_mode}), 32'h0000_0004);
    wake <= 1'b1;
    relay <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(32'({pin_oe_n, pin_out, pin_mode}), 32'h0000_0006);
    relay <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(32'({pin_oe_n, pin_out, pin_mode}), 32'h0000_0002);
    tally_and_finish();
  end
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
